/* logic/pcs_regs.svh */
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// Configuration dword holding command (low half) and status (high half)
`define PCS_CMD_OFFSET        8'h04
`define PCS_STS_OFFSET        8'h06
`define PCS_CSR_DWORD         6'h01

// Command field positions
`define PCS_CMD_IO_SPACE      0
`define PCS_CMD_MEM_SPACE     1
`define PCS_CMD_BUS_MASTER    2
`define PCS_CMD_SPECIAL       3
`define PCS_CMD_MWI_EN        4
`define PCS_CMD_PALETTE       5
`define PCS_CMD_PERR_RESP     6
`define PCS_CMD_STEPPING      7
`define PCS_CMD_SERR_EN       8
`define PCS_CMD_FAST_B2B      9
`define PCS_CMD_RESET         16'h0000

// Status field positions and fixed values
`define PCS_STS_CAP_LIST      4
`define PCS_STS_DATA_PERR     8
`define PCS_STS_SEL_LSB       9
`define PCS_STS_SEL_MSB       10
`define PCS_STS_SIG_TABORT    11
`define PCS_STS_RCV_TABORT    12
`define PCS_STS_RCV_MABORT    13
`define PCS_STS_SIG_SERR      14
`define PCS_STS_DET_PERR      15
`define PCS_STS_FIXED         16'h0210
`define PCS_SEL_SPEED_MEDIUM  2'h1

// Sticky flag indices inside the flag bank
`define PCS_FLAG_DATA_PERR    0
`define PCS_FLAG_SIG_TABORT   1
`define PCS_FLAG_RCV_TABORT   2
`define PCS_FLAG_RCV_MABORT   3
`define PCS_FLAG_SIG_SERR     4
`define PCS_FLAG_DET_PERR     5
`define PCS_FLAG_RESET        6'h00

// Gate channel indices
`define PCS_GATE_MEM          0
`define PCS_GATE_INIT         1
`define PCS_GATE_MWI          2
`define PCS_GATE_PERR         3
`define PCS_GATE_SERR         4

`endif

/* logic/pcs_pkg.sv */
`default_nettype none
package pcs_pkg;
  localparam int PCS_FLAGS = 6;
  localparam int PCS_GATES = 5;
  typedef logic [PCS_FLAGS-1:0] pcs_flags_type;
  typedef logic [PCS_GATES-1:0] pcs_gates_type;
  typedef logic [15:0]          pcs_half_type;
  typedef logic [31:0]          pcs_dword_type;
endpackage
`default_nettype wire

/* logic/pcs_flag_if.sv */
`default_nettype none
interface pcs_flag_if;
  import pcs_pkg::*;
  pcs_flags_type set;
  pcs_flags_type clr;
  pcs_flags_type q;
  modport bank (input set, input clr, output q);
  modport user (output set, output clr, input q);
endinterface
`default_nettype wire

/* logic/pcs_gate_if.sv */
`default_nettype none
interface pcs_gate_if;
  import pcs_pkg::*;
  pcs_gates_type req;
  pcs_gates_type en;
  pcs_gates_type out;
  modport gate (input req, input en, output out);
  modport user (output req, output en, input out);
endinterface
`default_nettype wire

/* logic/pcs_flag_bank.sv */
`default_nettype none
`include "pcs_regs.svh"
module pcs_flag_bank (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Flag set, clear and state
  pcs_flag_if.bank  flags
);
  import pcs_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PCS_FLAGS; i++) begin : g_flag
      // Set beats clear so an event in the clearing cycle survives
      always_ff @(posedge clk) begin
        if (!nrst) begin
          flags.q[i] <= 1'b0;
        end else if (flags.set[i]) begin
          flags.q[i] <= 1'b1; // R17
        end else if (flags.clr[i]) begin
          flags.q[i] <= 1'b0; // R11
        end
      end
    end
  endgenerate
endmodule // pcs_flag_bank
`default_nettype wire

/* logic/pcs_gate_bank.sv */
`default_nettype none
module pcs_gate_bank (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Requests, enables and gated outputs
  pcs_gate_if.gate  gates
);
  import pcs_pkg::*;

  genvar i;
  generate
    for (i = 0; i < PCS_GATES; i++) begin : g_gate
      always_ff @(posedge clk) begin
        if (!nrst) begin
          gates.out[i] <= 1'b0;
        end else begin
          gates.out[i] <= gates.req[i] & gates.en[i];
        end
      end
    end
  endgenerate
endmodule // pcs_gate_bank
`default_nettype wire

/* logic/pcs_cmd_status.sv */
// Notes on behaviour
// R01: Claim memory accesses only with memory enable
// R02: Start initiator cycles only with master enable
// R03: Write-and-invalidate allowed only when enabled
// R04: Parity error pin only with parity response
// R05: Detected parity flag ignores parity response
// R06: System error pin only with enable set
// R07: Writable command bits reset to zero
// R08: Unsupported command bits read zero, ignore writes
// R09: Select speed field reads medium, fixed
// R10: Data parity flag on own-initiator parity error
// R11: Sticky flags clear by writing one
// R12: Flag target aborts this target signalled
// R13: Flag target aborts received as initiator
// R14: Flag master aborts ended as initiator
// R15: Flag every system error assertion
// R16: Flag any address or data parity error
// R17: Set beats clear; zero writes change nothing
`default_nettype none
`include "pcs_regs.svh"
module pcs_cmd_status (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Configuration access port, one dword per access
  input  wire logic                 cfg_rd,
  input  wire logic                 cfg_wr,
  input  wire logic [7:0]           cfg_addr,
  input  wire logic [3:0]           cfg_be,
  input  wire pcs_pkg::pcs_dword_type cfg_wdata,
  output var  pcs_pkg::pcs_dword_type cfg_rdata,
  output var  logic                 cfg_ack,
  // Requests from the controller core
  input  wire logic                 mem_hit_req,
  input  wire logic                 init_start_req,
  input  wire logic                 mwi_want_req,
  input  wire logic                 perr_want_req,
  input  wire logic                 serr_want_req,
  // Error and abort events from the bus engine
  input  wire logic                 parity_err_evt,
  input  wire logic                 init_perr_evt,
  input  wire logic                 target_abort_sent_evt,
  input  wire logic                 target_abort_rcvd_evt,
  input  wire logic                 master_abort_evt,
  // Gated actions
  output var  logic                 mem_claim,
  output var  logic                 init_start,
  output var  logic                 mwi_use,
  output var  logic                 perr_assert,
  output var  logic                 serr_assert,
  // Command state
  output var  logic                 system_error_report_enable
);
  import pcs_pkg::*;

  pcs_flag_if flag_bus ();
  pcs_gate_if gate_bus ();

  logic          mem_en_reg;
  logic          init_en_reg;
  logic          mwi_en_reg;
  logic          perr_resp_reg;
  logic          serr_en_reg;
  logic          csr_hit;
  logic          wr_cmd_lo;
  logic          wr_cmd_hi;
  logic          wr_sts_hi;
  pcs_half_type  cmd_view;
  pcs_half_type  sts_view;
  pcs_flags_type flag_set_next;
  pcs_flags_type flag_clr_next;
  pcs_dword_type rdata_next;
  logic [1:0]    select_response_speed;

  assign csr_hit   = (cfg_addr[7:2] == `PCS_CSR_DWORD);
  assign wr_cmd_lo = cfg_wr & csr_hit & cfg_be[0];
  assign wr_cmd_hi = cfg_wr & csr_hit & cfg_be[1];
  assign wr_sts_hi = cfg_wr & csr_hit & cfg_be[3];
  assign select_response_speed = `PCS_SEL_SPEED_MEDIUM; // R09

  // Writable command bits; everything else is not stored at all
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_en_reg  <= 1'b0; // R07
      init_en_reg <= 1'b0; // R07
      mwi_en_reg  <= 1'b0; // R07
      perr_resp_reg <= 1'b0; // R07
    end else if (wr_cmd_lo) begin
      mem_en_reg    <= cfg_wdata[`PCS_CMD_MEM_SPACE];
      init_en_reg   <= cfg_wdata[`PCS_CMD_BUS_MASTER];
      mwi_en_reg    <= cfg_wdata[`PCS_CMD_MWI_EN];
      perr_resp_reg <= cfg_wdata[`PCS_CMD_PERR_RESP];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      serr_en_reg <= 1'b0; // R07
    end else if (wr_cmd_hi) begin
      serr_en_reg <= cfg_wdata[`PCS_CMD_SERR_EN];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      system_error_report_enable <= 1'b0;
    end else begin
      system_error_report_enable <= wr_cmd_hi ? cfg_wdata[`PCS_CMD_SERR_EN] : serr_en_reg;
    end
  end

  // Read view: unsupported and reserved bits stay zero
  always_comb begin
    cmd_view = `PCS_CMD_RESET; // R08
    cmd_view[`PCS_CMD_MEM_SPACE]  = mem_en_reg;
    cmd_view[`PCS_CMD_BUS_MASTER] = init_en_reg;
    cmd_view[`PCS_CMD_MWI_EN]     = mwi_en_reg;
    cmd_view[`PCS_CMD_PERR_RESP]  = perr_resp_reg;
    cmd_view[`PCS_CMD_SERR_EN]    = serr_en_reg;
  end

  always_comb begin
    sts_view = `PCS_STS_FIXED;
    sts_view[`PCS_STS_SEL_MSB:`PCS_STS_SEL_LSB] = select_response_speed; // R09
    sts_view[`PCS_STS_DATA_PERR]  = flag_bus.q[`PCS_FLAG_DATA_PERR];
    sts_view[`PCS_STS_SIG_TABORT] = flag_bus.q[`PCS_FLAG_SIG_TABORT];
    sts_view[`PCS_STS_RCV_TABORT] = flag_bus.q[`PCS_FLAG_RCV_TABORT];
    sts_view[`PCS_STS_RCV_MABORT] = flag_bus.q[`PCS_FLAG_RCV_MABORT];
    sts_view[`PCS_STS_SIG_SERR]   = flag_bus.q[`PCS_FLAG_SIG_SERR];
    sts_view[`PCS_STS_DET_PERR]   = flag_bus.q[`PCS_FLAG_DET_PERR];
  end

  // Flag causes
  always_comb begin
    flag_set_next = `PCS_FLAG_RESET;
    flag_set_next[`PCS_FLAG_DATA_PERR]  = init_perr_evt & perr_resp_reg; // R10
    flag_set_next[`PCS_FLAG_SIG_TABORT] = target_abort_sent_evt; // R12
    flag_set_next[`PCS_FLAG_RCV_TABORT] = target_abort_rcvd_evt; // R13
    flag_set_next[`PCS_FLAG_RCV_MABORT] = master_abort_evt; // R14
    flag_set_next[`PCS_FLAG_SIG_SERR]   = serr_assert; // R15
    flag_set_next[`PCS_FLAG_DET_PERR]   = parity_err_evt; // R05 R16
  end

  // Only ones in the status half clear; zeros leave flags alone
  always_comb begin
    flag_clr_next = `PCS_FLAG_RESET;
    if (wr_sts_hi) begin
      flag_clr_next[`PCS_FLAG_DATA_PERR]  = cfg_wdata[16+`PCS_STS_DATA_PERR]; // R11
      flag_clr_next[`PCS_FLAG_SIG_TABORT] = cfg_wdata[16+`PCS_STS_SIG_TABORT];
      flag_clr_next[`PCS_FLAG_RCV_TABORT] = cfg_wdata[16+`PCS_STS_RCV_TABORT];
      flag_clr_next[`PCS_FLAG_RCV_MABORT] = cfg_wdata[16+`PCS_STS_RCV_MABORT];
      flag_clr_next[`PCS_FLAG_SIG_SERR]   = cfg_wdata[16+`PCS_STS_SIG_SERR];
      flag_clr_next[`PCS_FLAG_DET_PERR]   = cfg_wdata[16+`PCS_STS_DET_PERR]; // R17
    end
  end

  assign flag_bus.set = flag_set_next;
  assign flag_bus.clr = flag_clr_next;

  pcs_flag_bank u_flags (
    .clk   (clk),
    .nrst  (nrst),
    .flags (flag_bus)
  );

  // Requests pass only while their enable holds
  assign gate_bus.req[`PCS_GATE_MEM]  = mem_hit_req;
  assign gate_bus.en[`PCS_GATE_MEM]   = mem_en_reg; // R01
  assign gate_bus.req[`PCS_GATE_INIT] = init_start_req;
  assign gate_bus.en[`PCS_GATE_INIT]  = init_en_reg; // R02
  // Write-and-invalidate is an initiator command, so needs both enables
  assign gate_bus.req[`PCS_GATE_MWI]  = mwi_want_req;
  assign gate_bus.en[`PCS_GATE_MWI]   = mwi_en_reg & init_en_reg; // R03
  assign gate_bus.req[`PCS_GATE_PERR] = perr_want_req;
  assign gate_bus.en[`PCS_GATE_PERR]  = perr_resp_reg; // R04
  assign gate_bus.req[`PCS_GATE_SERR] = serr_want_req;
  assign gate_bus.en[`PCS_GATE_SERR]  = serr_en_reg; // R06

  pcs_gate_bank u_gates (
    .clk   (clk),
    .nrst  (nrst),
    .gates (gate_bus)
  );

  assign mem_claim   = gate_bus.out[`PCS_GATE_MEM];
  assign init_start  = gate_bus.out[`PCS_GATE_INIT];
  assign mwi_use     = gate_bus.out[`PCS_GATE_MWI];
  assign perr_assert = gate_bus.out[`PCS_GATE_PERR];
  assign serr_assert = gate_bus.out[`PCS_GATE_SERR];

  // Registered read answer; other dwords read zero
  always_comb begin
    rdata_next = '0;
    if (cfg_rd && csr_hit) begin
      rdata_next = {sts_view, cmd_view};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_rdata <= '0;
    end else begin
      cfg_rdata <= rdata_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_rd | cfg_wr;
    end
  end
endmodule // pcs_cmd_status
`default_nettype wire

/* tb/pcs_cmd_status_checker.sv */
`default_nettype none
module pcs_cmd_status_checker (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   nrst,
  // Config port
  input wire logic                   cfg_rd,
  input wire logic                   cfg_wr,
  input wire logic [7:0]             cfg_addr,
  input wire pcs_pkg::pcs_dword_type cfg_rdata,
  input wire logic                   cfg_ack,
  // Gating
  input wire logic                   serr_want_req,
  input wire logic                   init_start_req,
  input wire logic                   serr_assert,
  input wire logic                   init_start,
  input wire logic                   system_error_report_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_map_rd;
    cfg_rd && cfg_addr[7:2] == 6'h01;
  endsequence
  chk_select_speed_fixed: assert property (s_map_rd |=> cfg_ack && cfg_rdata[26:25] == 2'h1 && cfg_rdata[20])
    else $error("select speed or capability bit wrong");
  chk_cmd_ro_zero: assert property (s_map_rd |=> (cfg_rdata[15:0] & 16'hFEA9) == 16'h0000)
    else $error("read-only command bit not zero");
  chk_serr_gate: assert property (serr_assert |-> $past(serr_want_req && system_error_report_enable))
    else $error("system error pin without request and enable");
  chk_serr_flag_set: assert property (serr_assert ##1 (s_map_rd and !cfg_wr) |=> cfg_rdata[30])
    else $error("system error flag not set");
  chk_init_gate: assert property (init_start |-> $past(init_start_req))
    else $error("initiator start without request");
  chk_enable_reset: assert property ($rose(nrst) |-> !system_error_report_enable && !serr_assert)
    else $error("enable not cleared by reset");
  chk_enable_by_write: assert property ($changed(system_error_report_enable) |-> $past(cfg_wr))
    else $error("enable changed without a write");
  // Reads come two cycles apart; no write between them may clear the flag
  chk_flag_sticky: assert property ((s_map_rd and !cfg_wr) ##1 (cfg_rdata[29] && !cfg_wr) ##1 (s_map_rd and !cfg_wr)
    |=> cfg_rdata[29])
    else $error("sticky flag dropped without a write");
endmodule // pcs_cmd_status_checker
`default_nettype wire

/* tb/pcs_host_model.sv */
`default_nettype none
module pcs_host_model (
  // Clock
  input wire logic                   clk,
  // Config cycle
  output var logic                   cfg_rd,
  output var logic                   cfg_wr,
  output var logic [7:0]             cfg_addr,
  output var logic [3:0]             cfg_be,
  output var pcs_pkg::pcs_dword_type cfg_wdata,
  input wire pcs_pkg::pcs_dword_type cfg_rdata,
  input wire logic                   cfg_ack
);
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;
  pcs_dword_type got;
  initial begin
    {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
  end
  // One pulse per access; missing ack poisons the returned data
  task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be, input pcs_dword_type d);
    cfg_wr <= w;
    cfg_rd <= !w;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    cfg_wdata <= ~d;
    // Answer stands in the cycle after the take; taken at its closing edge
    @(posedge clk);
    got = (cfg_ack === 1'b1) ? cfg_rdata : 32'hFFFF_FFFF;
  endtask
endmodule // pcs_host_model
`default_nettype wire

/* tb/pcs_cmd_status_tb.sv */
`default_nettype none
module pcs_cmd_status_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pcs_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] req = 5'h00;
  logic [4:0] evt = 5'h00;
  wire logic [4:0] gout;
  logic cfg_rd, cfg_wr, cfg_ack, sere;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be;
  pcs_dword_type cfg_wdata, cfg_rdata;
  logic [15:0] cmds [8] = '{16'h0156, 16'h0000, 16'h0010, 16'h0004, 16'h0014, 16'h0002, 16'h0040, 16'h0100};
  logic [4:0] exps [8] = '{5'h1F, 5'h00, 5'h00, 5'h02, 5'h06, 5'h01, 5'h08, 5'h10};
  int miscompares = 0;
  int samples_checked = 0;
  pcs_cmd_status pcs_cmd_status_i (.clk, .nrst, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata,
    .cfg_ack, .mem_hit_req(req[0]), .init_start_req(req[1]), .mwi_want_req(req[2]), .perr_want_req(req[3]),
    .serr_want_req(req[4]), .parity_err_evt(evt[0]), .init_perr_evt(evt[1]), .target_abort_sent_evt(evt[2]),
    .target_abort_rcvd_evt(evt[3]), .master_abort_evt(evt[4]), .mem_claim(gout[0]), .init_start(gout[1]),
    .mwi_use(gout[2]), .perr_assert(gout[3]), .serr_assert(gout[4]), .system_error_report_enable(sere));
  pcs_host_model pcs_host_model_i (.clk, .cfg_rd, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    pcs_host_model_i.access(1'b1, a, be, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    pcs_host_model_i.access(1'b0, a, 4'hF, 32'h0000_0000);
    chk("config read", exp, pcs_host_model_i.got);
  endtask
  // Every request at once, outputs looked at one cycle later
  task automatic gate(input logic [15:0] cmd, input logic [4:0] exp);
    wr(8'h04, 4'h3, {16'h0000, cmd});
    req <= 5'h1F;
    @(posedge clk);
    req <= 5'h00;
    @(posedge clk);
    chk("gated outputs", {27'h0, exp}, {27'h0, gout});
    chk("error report enable", {31'h0, cmd[8]}, {31'h0, sere});
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h04, 32'h0210_0000);
    wr(8'h04, 4'hF, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0210_0156);
    rd(8'h08, 32'h0000_0000);
    foreach (cmds[i]) gate(cmds[i], exps[i]);
    rd(8'h04, 32'h4210_0100);
    wr(8'h04, 4'hF, 32'hFFFF_0000);
    // Events last one edge only, the edge of the clear, so set must beat clear
    fork
      wr(8'h04, 4'h8, 32'hFF00_0000);
      begin
        evt <= 5'h1F;
        @(posedge clk);
        evt <= 5'h00;
      end
    join
    rd(8'h04, 32'hBA10_0000);
    rd(8'h04, 32'hBA10_0000);
    wr(8'h04, 4'h8, 32'h0000_0000);
    rd(8'h04, 32'hBA10_0000);
    wr(8'h04, 4'h8, 32'h2000_0000);
    rd(8'h04, 32'h9A10_0000);
    wr(8'h04, 4'hF, 32'hFFFF_0040);
    evt <= 5'h02;
    @(posedge clk);
    evt <= 5'h00;
    rd(8'h04, 32'h0310_0040);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h04, 32'h0210_0000);
    finish_test();
  end
endmodule // pcs_cmd_status_tb
bind pcs_cmd_status pcs_cmd_status_checker pcs_cmd_status_checker_i (.clk, .nrst, .cfg_rd, .cfg_wr, .cfg_addr,
  .cfg_rdata, .cfg_ack, .serr_want_req, .init_start_req, .serr_assert, .init_start, .system_error_report_enable);
`default_nettype wire
